// [hdl/pha_pkg.sv]
// Operation
// - The self-test byte of configuration dword 0Ch always reads zero.
// - The header type byte always reads zero, marking the type-0 layout.
// - The latency timer byte is a constant zero; the device never masters.
// - The cache line size byte always reads zero.
// - Base address bit 0 always reads one, declaring I/O space.
// - Base address bit 1 always reads zero.
// - Interrupt line byte is read/write storage and steers nothing.
// - Interrupt pin byte is read-only and always returns one.
// - Maximum latency byte always reads zero.
// - Index register sits at the I/O base, data register at base plus one.
// - Index bits 5:0 pick one of 64 socket registers for data access.
// - Index bit 6 picks the socket: zero first, one second.
// - Seven-bit index 00h-3Fh reaches socket one, 40h-7Fh socket two.
// - Each socket has 64 entries, sharing 1Eh and 1Fh; second-socket index equals first plus 40h.
// - Indices 01h-07h hold status, power, control and window enable bytes.
// - I/O windows 0 and 1 use indices 08h-0Bh and 0Ch-0Fh.
// - Memory windows 0, 1, 2 start at 10h, 18h, 20h, six bytes each.
// - Some index values are reserved and address no function.
// - The configuration header spans 00h-3Fh and is chip-wide.
package pha_pkg;

  // ----------------------------------------------------------------------
  // Configuration header dword offsets and fixed fields.
  // ----------------------------------------------------------------------
  localparam logic [5:0] CFG_DW_MISC   = 6'h03;  // Byte offset 0Ch.
  localparam logic [5:0] CFG_DW_IOBASE = 6'h04;  // Byte offset 10h.
  localparam logic [5:0] CFG_DW_INTR   = 6'h0f;  // Byte offset 3Ch.
  localparam logic [7:0] CFG_BIST      = 8'h00;
  localparam logic [7:0] CFG_HDR_TYPE  = 8'h00;
  localparam logic [7:0] CFG_LAT_TIMER = 8'h00;
  localparam logic [7:0] CFG_CACHE_LN  = 8'h00;
  localparam logic [7:0] CFG_INT_PIN   = 8'h01;
  localparam logic [7:0] CFG_MIN_GNT   = 8'h00;
  localparam logic [7:0] CFG_MAX_LAT   = 8'h00;
  localparam logic [1:0] BAR_IO_FLAGS  = 2'h1;   // Bit 1 zero, bit 0 one.
  localparam int         MAX_LAT_UNIT_NS = 250;
  localparam logic [7:0] INT_LINE_RST  = 8'h00;
  localparam logic [29:0] IO_BASE_RST  = 30'h00000000;

  // ----------------------------------------------------------------------
  // Index register layout and internal index space.
  // ----------------------------------------------------------------------
  localparam logic [7:0] INDEX_RST     = 8'h00;
  localparam int         IDX_SOCK_BIT  = 6;
  localparam int         IDX_REG_W     = 6;
  localparam logic [1:0] IO_LANE_INDEX = 2'h0;
  localparam logic [1:0] IO_LANE_DATA  = 2'h1;
  localparam logic [5:0] IDX_CHIP_REV  = 6'h00;
  localparam logic [5:0] IDX_SHARED0   = 6'h1e;
  localparam logic [5:0] IDX_SHARED1   = 6'h1f;
  localparam logic [5:0] IDX_RSVD_LO   = 6'h2c;
  localparam logic [5:0] IDX_RSVD_HI   = 6'h3f;
  localparam logic [5:0] IDX_IFC_STAT  = 6'h01;
  localparam logic [5:0] IDX_IO_WIN0   = 6'h08;
  localparam logic [5:0] IDX_IO_WIN1   = 6'h0c;
  localparam logic [5:0] IDX_MEM_WIN0  = 6'h10;
  localparam logic [5:0] IDX_MEM_WIN1  = 6'h18;
  localparam logic [5:0] IDX_MEM_WIN2  = 6'h20;
  localparam logic [7:0] REG_RST       = 8'h00;

  // Returns one for a socket register index that addresses no function.
  function automatic logic pha_idx_reserved(input logic [5:0] regIdx);
    return (regIdx >= IDX_RSVD_LO) && (regIdx <= IDX_RSVD_HI);
  endfunction

endpackage

// [hdl/pha_rf_if.sv]
// Byte access path from the index/data front end to the socket register file.
interface pha_rf_if;
  logic       wrEn;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport ctrl (output wrEn, output addr, output wdata, input rdata);
  modport file (input wrEn, input addr, input wdata, output rdata);
endinterface

// [hdl/pha_sock_regs.sv]
module pha_sock_regs #(
  parameter logic [7:0] CHIP_REV = 8'h5a  // Arbitrary revision code.
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  pha_rf_if.file    rf
);

  // ----------------------------------------------------------------------
  // Storage: 64 bytes per socket, socket selected by the top address bit.
  // ----------------------------------------------------------------------
  logic [7:0] mem_q [128];
  logic [5:0] regIdx;
  logic [6:0] eff;
  logic       writable;

  // Shared bytes of the second socket fold onto the first socket's copy.
  always_comb begin
    regIdx = rf.addr[5:0];
    eff    = rf.addr;
    if ((regIdx == pha_pkg::IDX_SHARED0) || (regIdx == pha_pkg::IDX_SHARED1)) begin
      eff = {1'b0, regIdx};
    end
    writable = !pha_pkg::pha_idx_reserved(regIdx) &&
               (regIdx != pha_pkg::IDX_CHIP_REV);
  end

  // Read mux: revision byte, reserved zeros, otherwise the stored byte.
  always_comb begin
    if (regIdx == pha_pkg::IDX_CHIP_REV) begin
      rf.rdata = CHIP_REV;
    end else if (pha_pkg::pha_idx_reserved(regIdx)) begin
      rf.rdata = 8'h00;
    end else begin
      rf.rdata = mem_q[eff];
    end
  end

  // Byte store; reserved writes are dropped.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 128; i++) begin
        mem_q[i] <= pha_pkg::REG_RST;
      end
    end else if (rf.wrEn && writable) begin
      mem_q[eff] <= rf.wdata;
    end
  end

endmodule // pha_sock_regs

// [hdl/pha_header_index.sv]
module pha_header_index #(
  parameter logic [7:0] CHIP_REV = 8'h5a  // Arbitrary revision code.
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        ioSpaceEn,
  input  wire logic        accValid,
  input  wire logic        accIsCfg,
  input  wire logic        accWrite,
  input  wire logic [31:0] accAddr,
  input  wire logic [3:0]  accByteEn,
  input  wire logic [31:0] accWdata,
  output logic             ioHit,
  output logic             accDone,
  output logic [31:0]      accRdata,
  output logic [31:0]      ioBase,
  output logic [7:0]       indexReg
);

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  logic [29:0] ioBase_q, ioBase_d;
  logic [7:0]  intLine_q, intLine_d;
  logic [7:0]  index_q, index_d;
  logic [31:0] rdata_q, rdata_d;
  logic        done_q, done_d;
  logic        cfgAcc, ioAcc;
  logic [5:0]  cfgDw;

  pha_rf_if rf ();

  // Byte lanes of the index and data registers within the claimed dword.
  localparam int IO_LANE_IDX = int'(pha_pkg::IO_LANE_INDEX);
  localparam int IO_LANE_DAT = int'(pha_pkg::IO_LANE_DATA);

  pha_sock_regs #(
    .CHIP_REV (CHIP_REV)
  ) u_regs (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .rf      (rf.file)
  );

  // ----------------------------------------------------------------------
  // Decode.
  // ----------------------------------------------------------------------
  // Configuration cycles reach the chip-wide header; I/O cycles hit the dword at the base.
  always_comb begin
    cfgDw  = accAddr[7:2];
    ioHit  = accValid && !accIsCfg && ioSpaceEn &&
             (accAddr[31:2] == ioBase_q) &&
             (accByteEn[IO_LANE_IDX] || accByteEn[IO_LANE_DAT]);
    cfgAcc = accValid && accIsCfg && !done_q;
    ioAcc  = ioHit && !done_q;
  end

  // Data register path: byte at base plus one, addressed by the index.
  always_comb begin
    rf.addr  = index_q[6:0];
    rf.wdata = accWdata[15:8];
    rf.wrEn  = ioAcc && accWrite && accByteEn[IO_LANE_DAT];
  end

  // ----------------------------------------------------------------------
  // Next state and read data.
  // ----------------------------------------------------------------------
  // Writes update stored fields; read-only bits take no write.
  always_comb begin
    ioBase_d  = ioBase_q;
    intLine_d = intLine_q;
    index_d   = index_q;
    rdata_d   = rdata_q;
    done_d    = cfgAcc || ioAcc;
    if (cfgAcc) begin
      unique case (cfgDw)
        pha_pkg::CFG_DW_MISC: begin
          rdata_d = {pha_pkg::CFG_BIST, pha_pkg::CFG_HDR_TYPE,
                     pha_pkg::CFG_LAT_TIMER, pha_pkg::CFG_CACHE_LN};
        end
        pha_pkg::CFG_DW_IOBASE: begin
          rdata_d = {ioBase_q, pha_pkg::BAR_IO_FLAGS};
          if (accWrite) begin
            for (int b = 0; b < 4; b++) begin
              if (accByteEn[b]) begin
                ioBase_d = ioWriteByte(ioBase_d, b, accWdata);
              end
            end
          end
        end
        pha_pkg::CFG_DW_INTR: begin
          rdata_d = {pha_pkg::CFG_MAX_LAT, pha_pkg::CFG_MIN_GNT,
                     pha_pkg::CFG_INT_PIN, intLine_q};
          if (accWrite && accByteEn[0]) begin
            intLine_d = accWdata[7:0];
          end
        end
        default: begin
          rdata_d = 32'h00000000;
        end
      endcase
    end else if (ioAcc) begin
      rdata_d = {16'h0000, rf.rdata, index_q};
      if (accWrite && accByteEn[IO_LANE_IDX]) begin
        index_d = accWdata[7:0];
      end
    end
  end

  // Merges one written byte into the base field, keeping bits 1:0 out.
  function automatic logic [29:0] ioWriteByte(input logic [29:0] cur, input int lane,
                                              input logic [31:0] wd);
    logic [31:0] full;
    full = {cur, 2'b00};
    full[lane*8 +: 8] = wd[lane*8 +: 8];
    return full[31:2];
  endfunction

  // Registers all state.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ioBase_q  <= pha_pkg::IO_BASE_RST;
      intLine_q <= pha_pkg::INT_LINE_RST;
      index_q   <= pha_pkg::INDEX_RST;
      rdata_q   <= 32'h00000000;
      done_q    <= 1'b0;
    end else begin
      ioBase_q  <= ioBase_d;
      intLine_q <= intLine_d;
      index_q   <= index_d;
      rdata_q   <= rdata_d;
      done_q    <= done_d;
    end
  end

  // Outputs.
  always_comb begin
    accDone  = done_q;
    accRdata = rdata_q;
    ioBase   = {ioBase_q, pha_pkg::BAR_IO_FLAGS};
    indexReg = index_q;
  end

endmodule // pha_header_index

// [test/pha_header_index_props.sv]
module pha_header_index_props (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        ioSpaceEn,
  input wire logic        accValid,
  input wire logic        accIsCfg,
  input wire logic        accWrite,
  input wire logic [31:0] accAddr,
  input wire logic [3:0]  accByteEn,
  input wire logic [31:0] accWdata,
  input wire logic        ioHit,
  input wire logic        accDone,
  input wire logic [31:0] accRdata,
  input wire logic [31:0] ioBase,
  input wire logic [7:0]  indexReg
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // A request is taken at this edge; the second form narrows it to a config read.
  sequence taken;
    accValid && !accDone && (accIsCfg || ioHit);
  endsequence
  sequence cfgRd(logic [5:0] dw);
    taken ##0 accIsCfg && !accWrite && accAddr[7:2] == dw;
  endsequence
  answer_one_cycle_a: assert property (taken |=> accDone ##1 !accDone)
    else $error("answer missing or longer than one cycle");
  io_miss_ignored_a: assert property (accValid && !accDone && !accIsCfg && !ioHit |=> !accDone)
    else $error("unclaimed cycle was answered");
  hit_decode_a: assert property (accValid && !accIsCfg |-> ioHit == (ioSpaceEn &&
    accAddr[31:2] == ioBase[31:2] && (accByteEn[0] || accByteEn[1])))
    else $error("claim does not match base and lanes");
  misc_fixed_a: assert property (cfgRd(pha_pkg::CFG_DW_MISC) |=> accRdata == 32'h0)
    else $error("fixed dword not zero");
  bar_read_a: assert property (cfgRd(pha_pkg::CFG_DW_IOBASE) |=> accRdata == ioBase && accRdata[1:0] == 2'h1)
    else $error("base register read wrong");
  intr_fixed_a: assert property (cfgRd(pha_pkg::CFG_DW_INTR) |=> accRdata[31:8] == 24'h000001)
    else $error("interrupt dword fixed bytes wrong");
  bar_write_a: assert property (taken ##0 accIsCfg && accWrite && accByteEn == 4'hf &&
    accAddr[7:2] == pha_pkg::CFG_DW_IOBASE |=> ioBase[31:2] == $past(accWdata[31:2]))
    else $error("base register not written");
  index_write_a: assert property (taken ##0 !accIsCfg && accWrite && accByteEn[0]
    |=> indexReg == $past(accWdata[7:0]))
    else $error("index register not written");
  upper_lanes_a: assert property (taken ##0 !accIsCfg && !accWrite |=> accRdata[31:16] == 16'h0)
    else $error("unused lanes not zero");
endmodule // pha_header_index_props

bind pha_header_index pha_header_index_props u_props (.ref_clk(ref_clk), .rst_n(rst_n),
  .ioSpaceEn(ioSpaceEn), .accValid(accValid), .accIsCfg(accIsCfg), .accWrite(accWrite),
  .accAddr(accAddr), .accByteEn(accByteEn), .accWdata(accWdata), .ioHit(ioHit),
  .accDone(accDone), .accRdata(accRdata), .ioBase(ioBase), .indexReg(indexReg));

// [test/pha_host_model.sv]
module pha_host_model (
  input  wire logic        ref_clk,
  input  wire logic        accDone,
  output logic             accValid,
  output logic             accIsCfg,
  output logic             accWrite,
  output logic [31:0]      accAddr,
  output logic [3:0]       accByteEn,
  output logic [31:0]      accWdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // The bus is idle from time zero.
  initial begin
    accValid = 1'b0;
    accIsCfg = 1'b0;
    accWrite = 1'b0;
    accAddr = 32'h0;
    accByteEn = 4'h0;
    accWdata = 32'h0;
  end
  // One access: held until the answer has been sampled or four cycles pass unanswered, then released with scrambled lines.
  task automatic acc(input logic cfg, wr, input logic [31:0] a, input logic [3:0] be,
                     input logic [31:0] wd, output logic hit);
    hit = 1'b0;
    @(negedge ref_clk);
    accIsCfg = cfg;
    accWrite = wr;
    accAddr = a;
    accByteEn = be;
    accWdata = wd;
    accValid = 1'b1;
    for (int n = 0; n < 4 && !hit; n++) begin
      @(negedge ref_clk);
      hit = (accDone === 1'b1);
    end
    if (hit) @(negedge ref_clk);
    accValid = 1'b0;
    accAddr = ~a;
    accWdata = ~wd;
  endtask
endmodule // pha_host_model

// [test/tb_pci_header_and_index_port.sv]
module tb_pci_header_and_index_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ioSpaceEn = 1'b0;
  logic        accValid, accIsCfg, accWrite, accDone, ioHit;
  logic [31:0] accAddr, accWdata, accRdata, ioBase, base, lfsrQ, expQ[$], mskQ[$];
  logic [3:0]  accByteEn;
  logic [7:0]  indexReg, ix, vals[12];
  logic [5:0]  idxTab[6] = '{6'h08, 6'h0c, 6'h10, 6'h18, 6'h20, 6'h2c};
  int          err_total = 0;
  int          checks_done = 0;

  always #2.5 ref_clk = ~ref_clk;

  pha_header_index DUT (.ref_clk(ref_clk), .rst_n(rst_n), .ioSpaceEn(ioSpaceEn),
    .accValid(accValid), .accIsCfg(accIsCfg), .accWrite(accWrite), .accAddr(accAddr),
    .accByteEn(accByteEn), .accWdata(accWdata), .ioHit(ioHit), .accDone(accDone),
    .accRdata(accRdata), .ioBase(ioBase), .indexReg(indexReg));
  pha_host_model u_host (.ref_clk(ref_clk), .accDone(accDone), .accValid(accValid),
    .accIsCfg(accIsCfg), .accWrite(accWrite), .accAddr(accAddr), .accByteEn(accByteEn),
    .accWdata(accWdata));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Masked comparison of a result against its expectation.
  task automatic cmp32(input string name, input logic [31:0] e, g, m);
    checks_done++;
    if ((g & m) !== (e & m)) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask

  // Notes the expected read data, runs the access and checks whether it was claimed.
  task automatic op(input logic cfg, wr, input logic [31:0] a, input logic [3:0] be,
                    input logic [31:0] wd, e, m, input logic eh);
    logic hit;
    if (eh) expQ.push_back(e);
    if (eh) mskQ.push_back(m);
    u_host.acc(cfg, wr, a, be, wd, hit);
    cmp32("claim", {31'h0, eh}, {31'h0, hit}, 32'h1);
  endtask

  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Each answer takes the oldest expectation off the queue, sampled mid-cycle.
  always @(negedge ref_clk) begin
    if (accDone === 1'b1 && expQ.size() == 0)
      cmp32("answer", 32'h0, 32'h1, 32'h1);
    else if (accDone === 1'b1)
      cmp32("accRdata", expQ.pop_front(), accRdata, mskQ.pop_front());
  end

  // Cuts a hang short.
  initial begin
    repeat (3000) @(posedge ref_clk);
    err_total++;
    end_sim();
  end

  // Main sequence: header fields, base placement, then indexed socket bytes.
  initial begin
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    lfsrQ = lfsr_next(32'h709cbf32);
    base = {lfsrQ[31:2], 2'h0};
    op(1'b1, 1'b0, 32'h0c, 4'hf, 32'h0, 32'h0, '1, 1'b1);
    op(1'b1, 1'b0, 32'h10, 4'hf, 32'h0, 32'h1, '1, 1'b1);
    op(1'b1, 1'b1, 32'h10, 4'hf, base, 32'h0, 32'h0, 1'b1);
    op(1'b1, 1'b0, 32'h10, 4'hf, 32'h0, base | 32'h1, '1, 1'b1);
    op(1'b1, 1'b1, 32'h3c, 4'hf, {24'h0, lfsrQ[7:0]}, 32'h0, 32'h0, 1'b1);
    op(1'b1, 1'b0, 32'h3c, 4'hf, 32'h0, {16'h0001, lfsrQ[7:0]}, '1, 1'b1);
    op(1'b0, 1'b0, base, 4'h3, 32'h0, 32'h0, 32'h0, 1'b0);
    ioSpaceEn = 1'b1;
    op(1'b0, 1'b0, base + 32'h4, 4'h3, 32'h0, 32'h0, 32'h0, 1'b0);
    for (int i = 0; i < 12; i++) begin
      lfsrQ = lfsr_next(lfsrQ);
      vals[i] = lfsrQ[7:0];
      ix = {1'b0, i[0], idxTab[i / 2]};
      op(1'b0, 1'b1, base, 4'h1, {24'h0, ix}, 32'h0, 32'h0, 1'b1);
      op(1'b0, 1'b1, base, 4'h2, {16'h0, vals[i], 8'h0}, 32'h0, 32'h0, 1'b1);
    end
    for (int i = 0; i < 12; i++) begin
      ix = {1'b0, i[0], idxTab[i / 2]};
      op(1'b0, 1'b1, base, 4'h1, {24'h0, ix}, 32'h0, 32'h0, 1'b1);
      op(1'b0, 1'b0, base, 4'h3, 32'h0, {16'h0, (i / 2 == 5) ? 8'h00 : vals[i], ix}, '1,
         1'b1);
    end
    end_sim();
  end
endmodule // tb_pci_header_and_index_port
